// ### rtl/tpps_config_loader.v
// Power-up sequencing and serial configuration port of the transceiver
// How it works
// RULE_01: Host waits 2 ms for crystal start
// RULE_02: Host writes only after 10 us regulator
// RULE_03: Word is 32 shift clocks, max 25 MHz
// RULE_04: Oscillator ready after 1 ms, overlapping crystal
// RULE_05: Transmit needs divider, oscillator, modulation words
// RULE_06: Receive also needs demodulator and filter words
// RULE_07: Mode change rewrites divider, flips transmit/receive
// RULE_08: Gain loop settles about 150 us in receive
// RULE_09: Clock recovery locks after five bit transitions
// RULE_10: Frequency loop locks after sixteen transitions
// RULE_11: Far transmitter sends dc-free preamble
// RULE_12: Runs up to six bits tolerated
// RULE_13: Test word routes signal strength to pin; loader only sets test_rssi_route, pin stays on regulator status
// RULE_14: MSB first, latch strobe rise, low nibble address
// RULE_15: Port ignores traffic while enable low
// RULE_16: Host waits longest start-up, then signals done
`timescale 1ns/1ps
`default_nettype none
`include "tpps_consts.vh"

module tpps_config_loader #(
	parameter [`TPPS_TMR_W-1:0] VCO_UP_CYC     = `TPPS_VCO_UP_CYC,
	parameter [`TPPS_TMR_W-1:0] XTAL_UP_CYC    = `TPPS_XTAL_UP_CYC,
	parameter [`TPPS_TMR_W-1:0] AGC_SETTLE_CYC = `TPPS_AGC_SETTLE_CYC
) (
	input  wire                    sys_clk,
	input  wire                    rst,
	input  wire                    chip_enable,
	input  wire                    sclk,
	input  wire                    sdata,
	input  wire                    latch_strobe,
	input  wire                    bit_tick,
	input  wire                    rx_bit,
	output reg                     multiplexed_status_pin,
	output reg                     vco_ready,
	output reg                     xtal_ready,
	output reg                     cfg_valid,
	output reg  [`TPPS_WORD_W-1:0] cfg_word,
	output reg  [`TPPS_ADDR_W-1:0] cfg_addr,
	output reg                     rx_mode,
	output reg                     tx_configured,
	output reg                     rx_configured,
	output reg                     agc_settled,
	output reg                     cdr_locked,
	output reg                     afc_locked,
	output reg                     run_violation,
	output reg                     test_rssi_route
);

	localparam [`TPPS_TMR_W-1:0] REG_UP_CYC = `TPPS_REG_UP_CYC;
	// Timer must run on to the slowest of the three start-up marks
	localparam [`TPPS_TMR_W-1:0] SLOW_UP_CYC =
		(XTAL_UP_CYC > REG_UP_CYC) ? XTAL_UP_CYC : REG_UP_CYC;
	localparam [`TPPS_TMR_W-1:0] UP_LIMIT =
		(VCO_UP_CYC > SLOW_UP_CYC) ? VCO_UP_CYC : SLOW_UP_CYC;

	function [`TPPS_TMR_W-1:0] sat_inc;
		input [`TPPS_TMR_W-1:0] value;
		input [`TPPS_TMR_W-1:0] limit;
		begin
			if (value >= limit)
				sat_inc = limit;
			else
				sat_inc = value + 1'b1;
		end
	endfunction

	// ****************************************************
	// Pin synchronisers
	// ****************************************************
	reg [1:0] ce_sync;
	reg [1:0] sclk_sync;
	reg [1:0] sdata_sync;
	reg [1:0] sle_sync;
	reg       sclk_prev;
	reg       sle_prev;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ce_sync    <= 2'h0;
			sclk_sync  <= 2'h0;
			sdata_sync <= 2'h0;
			sle_sync   <= 2'h0;
			sclk_prev  <= 1'b0;
			sle_prev   <= 1'b0;
		end else begin
			ce_sync    <= {ce_sync[0], chip_enable};
			sclk_sync  <= {sclk_sync[0], sclk};
			sdata_sync <= {sdata_sync[0], sdata};
			sle_sync   <= {sle_sync[0], latch_strobe};
			sclk_prev  <= sclk_sync[1];
			sle_prev   <= sle_sync[1];
		end
	end

	wire ce_on     = ce_sync[1];
	wire sclk_rise = sclk_sync[1] & ~sclk_prev;
	wire sle_rise  = sle_sync[1] & ~sle_prev;

	// ****************************************************
	// Start-up timing from enable
	// ****************************************************
	reg  [`TPPS_TMR_W-1:0] up_cnt;
	wire                   reg_up = (up_cnt >= REG_UP_CYC);

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			up_cnt                 <= {`TPPS_TMR_W{1'b0}};
			multiplexed_status_pin <= 1'b0;
			vco_ready              <= 1'b0;
			xtal_ready             <= 1'b0;
		end else if (!ce_on) begin
			up_cnt                 <= {`TPPS_TMR_W{1'b0}};
			multiplexed_status_pin <= 1'b0;
			vco_ready              <= 1'b0;
			xtal_ready             <= 1'b0;
		end else begin
			// One counter serves both oscillators, so they start together
			up_cnt                 <= sat_inc(up_cnt, UP_LIMIT); // RULE_04
			multiplexed_status_pin <= reg_up;
			vco_ready              <= (up_cnt >= VCO_UP_CYC); // RULE_04
			xtal_ready             <= (up_cnt >= XTAL_UP_CYC);
		end
	end

	// ****************************************************
	// Serial shift register and latches
	// ****************************************************
	reg [`TPPS_WORD_W-1:0]    shift;
	reg [`TPPS_NUM_LATCH-1:0] written;
	wire [`TPPS_ADDR_W-1:0]   new_addr = shift[`TPPS_ADDR_MSB:0];
	wire                      port_on  = ce_on & reg_up;
	wire                      take     = port_on & sle_rise;
	wire                      in_map   = (new_addr < `TPPS_NUM_LATCH);
	wire                      is_test  = (shift == `TPPS_TEST_RSSI_WORD);
	wire                      div_take = take & (new_addr == `TPPS_REG_DIV);

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shift <= {`TPPS_WORD_W{1'b0}};
		end else if (!port_on) begin
			shift <= {`TPPS_WORD_W{1'b0}}; // RULE_15
		end else begin
			if (sclk_rise)
				shift <= {shift[`TPPS_WORD_W-2:0], sdata_sync[1]}; // RULE_14
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			written         <= {`TPPS_NUM_LATCH{1'b0}};
			cfg_valid       <= 1'b0;
			cfg_word        <= {`TPPS_WORD_W{1'b0}};
			cfg_addr        <= {`TPPS_ADDR_W{1'b0}};
			rx_mode         <= 1'b0;
			test_rssi_route <= 1'b0;
			tx_configured   <= 1'b0;
			rx_configured   <= 1'b0;
		end else if (!ce_on) begin
			written         <= {`TPPS_NUM_LATCH{1'b0}};
			cfg_valid       <= 1'b0;
			rx_mode         <= 1'b0;
			test_rssi_route <= 1'b0;
			tx_configured   <= 1'b0;
			rx_configured   <= 1'b0;
		end else begin
			cfg_valid <= take & in_map;
			if (take && in_map) begin
				cfg_word         <= shift;
				cfg_addr         <= new_addr;
				written[new_addr] <= 1'b1;
			end
			if (div_take)
				rx_mode <= ~shift[`TPPS_TXRX_BIT]; // RULE_07
			if (take && is_test)
				test_rssi_route <= 1'b1; // RULE_13
			tx_configured <= written[`TPPS_REG_DIV] & written[`TPPS_REG_OSC]
				& written[`TPPS_REG_MOD]; // RULE_05
			rx_configured <= written[`TPPS_REG_DIV] & written[`TPPS_REG_OSC]
				& written[`TPPS_REG_MOD] & written[`TPPS_REG_DEMOD]
				& written[`TPPS_REG_FILT]; // RULE_06
		end
	end

	// ****************************************************
	// Receive acquisition: gain, clock and frequency loops
	// ****************************************************
	reg  [`TPPS_TMR_W-1:0] agc_cnt;
	reg  [`TPPS_EDGE_W-1:0] edge_cnt;
	reg  [`TPPS_RUN_W-1:0]  run_len;
	reg                     last_bit;
	wire rx_active = rx_mode & rx_configured & xtal_ready & ~div_take;
	wire bit_edge  = bit_tick & (rx_bit != last_bit);

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			agc_cnt       <= {`TPPS_TMR_W{1'b0}};
			agc_settled   <= 1'b0;
			edge_cnt      <= {`TPPS_EDGE_W{1'b0}};
			cdr_locked    <= 1'b0;
			afc_locked    <= 1'b0;
			run_len       <= {`TPPS_RUN_W{1'b0}};
			last_bit      <= 1'b0;
			run_violation <= 1'b0;
		end else if (!rx_active) begin
			// A divider rewrite restarts acquisition on the new channel
			agc_cnt       <= {`TPPS_TMR_W{1'b0}};
			agc_settled   <= 1'b0;
			edge_cnt      <= {`TPPS_EDGE_W{1'b0}};
			cdr_locked    <= 1'b0;
			afc_locked    <= 1'b0;
			run_len       <= {`TPPS_RUN_W{1'b0}};
			run_violation <= 1'b0;
		end else begin
			agc_cnt     <= sat_inc(agc_cnt, AGC_SETTLE_CYC); // RULE_08
			agc_settled <= (agc_cnt >= AGC_SETTLE_CYC); // RULE_08
			if (bit_edge && edge_cnt < `TPPS_AFC_EDGES)
				edge_cnt <= edge_cnt + 1'b1;
			cdr_locked <= (edge_cnt >= `TPPS_CDR_EDGES); // RULE_09
			afc_locked <= (edge_cnt >= `TPPS_AFC_EDGES); // RULE_10
			if (bit_tick) begin
				last_bit <= rx_bit;
				if (bit_edge)
					run_len <= {{(`TPPS_RUN_W-1){1'b0}}, 1'b1};
				else if (run_len < `TPPS_MAX_RUN)
					run_len <= run_len + 1'b1;
				else
					run_violation <= 1'b1; // RULE_12
			end
		end
	end

endmodule
`default_nettype wire

// ### rtl/tpps_consts.vh
// Constants for the power-up and configuration loader of the transceiver
`ifndef TPPS_CONSTS_VH
`define TPPS_CONSTS_VH

// ****************************************************
// Clock and start-up times
// ****************************************************
`define TPPS_CLK_MHZ        100
`define TPPS_REG_UP_US      10
`define TPPS_VCO_UP_US      1000
`define TPPS_XTAL_UP_US     2000
`define TPPS_AGC_SETTLE_US  150
// Same times in clock cycles, sized to the start-up timer width
`define TPPS_REG_UP_CYC     18'h0_03E8
`define TPPS_VCO_UP_CYC     18'h1_86A0
`define TPPS_XTAL_UP_CYC    18'h3_0D40
`define TPPS_AGC_SETTLE_CYC 18'h0_3A98
`define TPPS_TMR_W          18

// ****************************************************
// Serial word layout
// ****************************************************
`define TPPS_WORD_W         32
`define TPPS_ADDR_MSB       3
`define TPPS_ADDR_W         4
`define TPPS_NUM_LATCH      11
`define TPPS_TXRX_BIT       27
`define TPPS_REG_DIV        4'h0
`define TPPS_REG_OSC        4'h1
`define TPPS_REG_MOD        4'h2
`define TPPS_REG_DEMOD      4'h4
`define TPPS_REG_FILT       4'h6
`define TPPS_TEST_RSSI_WORD 32'h3800_000C

// ****************************************************
// Receiver acquisition
// ****************************************************
`define TPPS_CDR_EDGES      5'h05
`define TPPS_AFC_EDGES      5'h10
`define TPPS_MAX_RUN        3'h6
`define TPPS_RUN_W          3
`define TPPS_EDGE_W         5

`endif

// ### test/tpps_host_model.sv
// Host model driving the three-wire configuration port
`timescale 1ns/1ps
`default_nettype none
module tpps_host_model (
	input  wire logic sys_clk,
	output var  logic sclk,
	output var  logic sdata,
	output var  logic latch_strobe
);
	// ****************
	// Word shifter
	// ****************
	initial begin
		sclk = 1'b0;
		sdata = 1'b0;
		latch_strobe = 1'b0;
	end
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(negedge sys_clk);
			sdata <= w[i];
			sclk <= 1'b0;
			repeat (3) @(negedge sys_clk);
			sclk <= 1'b1;
			repeat (3) @(negedge sys_clk);
		end
		sclk <= 1'b0;
		latch_strobe <= 1'b1;
		sdata <= ~sdata;
		repeat (4) @(negedge sys_clk);
		latch_strobe <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### test/tpps_chk.sv
// Assertion checker for the configuration loader ports
`timescale 1ns/1ps
`default_nettype none
module tpps_chk (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        chip_enable,
	input wire logic        multiplexed_status_pin,
	input wire logic        vco_ready,
	input wire logic        xtal_ready,
	input wire logic        cfg_valid,
	input wire logic [31:0] cfg_word,
	input wire logic [3:0]  cfg_addr,
	input wire logic        rx_mode,
	input wire logic        tx_configured,
	input wire logic        rx_configured,
	input wire logic        cdr_locked,
	input wire logic        afc_locked,
	input wire logic        test_rssi_route
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_valid_pulse:
		assert property (cfg_valid |=> !cfg_valid) else $error("long valid");
	a_addr_range:
		assert property (cfg_valid |-> cfg_addr <= 4'ha) else $error("addr");
	a_txrx_bit:
		assert property (cfg_valid && cfg_addr == 4'h0 |->
			rx_mode == !cfg_word[27]) else $error("rx_mode");
	a_vco_first:
		assert property (xtal_ready |-> vco_ready) else $error("vco order");
	a_off_clears:
		assert property (!chip_enable [*4] |-> !vco_ready && !tx_configured
			&& !cfg_valid) else $error("enable low");
	a_reg_before:
		assert property (cfg_valid |-> multiplexed_status_pin)
			else $error("write before regulator");
	a_afc_order:
		assert property (afc_locked |-> cdr_locked) else $error("afc order");
	a_rx_superset:
		assert property (rx_configured |-> tx_configured) else $error("rx cfg");
	a_route_sticky:
		assert property ($fell(test_rssi_route) |-> !chip_enable)
			else $error("route dropped");
endmodule
bind tpps_config_loader tpps_chk tpps_chk_i (.sys_clk, .rst, .chip_enable,
	.multiplexed_status_pin, .vco_ready, .xtal_ready, .cfg_valid, .cfg_word,
	.cfg_addr, .rx_mode, .tx_configured, .rx_configured, .cdr_locked,
	.afc_locked, .test_rssi_route);
`default_nettype wire

// ### test/test_transceiver_powerup_programming_sequence.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "tpps_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	mismatches++; $display("Error %s exp %h got %h", n, e, g); end end
module test_transceiver_powerup_programming_sequence;
	logic sys_clk, rst, chip_enable, bit_tick, rx_bit;
	wire sclk, sdata, latch_strobe, multiplexed_status_pin, vco_ready;
	wire xtal_ready, cfg_valid, rx_mode, tx_configured, rx_configured;
	wire agc_settled, cdr_locked, afc_locked, run_violation, test_rssi_route;
	wire [31:0] cfg_word;
	wire [3:0]  cfg_addr;
	int mismatches, check_count, nvalid;
	tpps_config_loader #(.VCO_UP_CYC(18'd200), .XTAL_UP_CYC(18'd400),
		.AGC_SETTLE_CYC(18'd50)) tpps_config_loader_i (.sys_clk, .rst,
		.chip_enable, .sclk, .sdata, .latch_strobe, .bit_tick, .rx_bit,
		.multiplexed_status_pin, .vco_ready, .xtal_ready, .cfg_valid,
		.cfg_word, .cfg_addr, .rx_mode, .tx_configured, .rx_configured,
		.agc_settled, .cdr_locked, .afc_locked, .run_violation,
		.test_rssi_route);
	tpps_host_model tpps_host_model_i (.sys_clk, .sclk, .sdata, .latch_strobe);
	// ****************
	// Helpers
	// ****************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (cfg_valid === 1'b1) nvalid++;
	task final_report;
		if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task wr(input logic [31:0] w, input int exp);
		int n0;
		n0 = nvalid;
		tpps_host_model_i.send(w);
		repeat (4) @(negedge sys_clk);
		`CHK("cfg_valid count", exp, nvalid - n0)
	endtask
	task bits(input int n, input logic tog);
		repeat (n) begin
			@(negedge sys_clk);
			rx_bit <= rx_bit ^ tog;
			bit_tick <= 1'b1;
			@(negedge sys_clk);
			bit_tick <= 1'b0;
			repeat (2) @(negedge sys_clk);
		end
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_power;
		int i;
		chip_enable <= 1'b1;
		repeat (195) @(negedge sys_clk);
		`CHK("vco early", 1'b0, vco_ready)
		repeat (15) @(negedge sys_clk);
		`CHK("vco", 1'b1, vco_ready)
		`CHK("xtal early", 1'b0, xtal_ready)
		`CHK("reg early", 1'b0, multiplexed_status_pin)
		repeat (200) @(negedge sys_clk);
		`CHK("xtal", 1'b1, xtal_ready)
		wr(32'h0800_0000, 0);
		for (i = 0; i < 1200 && multiplexed_status_pin !== 1'b1; i++)
			@(negedge sys_clk);
		if (i == 1200) begin
			mismatches++;
			final_report();
		end
	endtask
	task t_tx;
		`CHK("start-up done", 1'b1, xtal_ready & vco_ready)
		wr(32'h0800_0000, 1);
		`CHK("rx_mode tx", 1'b0, rx_mode)
		wr(32'h0000_0001, 1);
		wr(32'hA5C3_0012, 1);
		`CHK("tx cfg", 1'b1, tx_configured)
		`CHK("rx cfg", 1'b0, rx_configured)
		wr(32'h0000_000B, 0);
		`CHK("cfg_word kept", 32'hA5C3_0012, cfg_word)
		`CHK("cfg_addr kept", 4'h2, cfg_addr)
	endtask
	task t_rx;
		wr(32'h0000_0004, 1);
		wr(32'h0000_0006, 1);
		`CHK("rx cfg", 1'b1, rx_configured)
		wr(32'h0000_0000, 1);
		`CHK("rx_mode rx", 1'b1, rx_mode)
		`CHK("agc early", 1'b0, agc_settled)
		bits(3, 1'b1);
		`CHK("cdr early", 1'b0, cdr_locked)
		bits(3, 1'b1);
		`CHK("cdr", 1'b1, cdr_locked)
		`CHK("afc early", 1'b0, afc_locked)
		bits(12, 1'b1);
		`CHK("afc", 1'b1, afc_locked)
		`CHK("agc", 1'b1, agc_settled)
		bits(1, 1'b1);
		bits(5, 1'b0);
		`CHK("run of six", 1'b0, run_violation)
		bits(1, 1'b0);
		`CHK("run of seven", 1'b1, run_violation)
	endtask
	task t_test;
		wr(`TPPS_TEST_RSSI_WORD, 0);
		`CHK("rssi route", 1'b1, test_rssi_route)
	endtask
	task t_off;
		chip_enable <= 1'b0;
		repeat (4) @(negedge sys_clk);
		`CHK("tx cfg off", 1'b0, tx_configured)
		`CHK("cdr off", 1'b0, cdr_locked)
		wr(32'h0800_0000, 0);
		`CHK("reg off", 1'b0, multiplexed_status_pin)
	endtask
	initial begin
		rst = 1'b1;
		chip_enable = 1'b0;
		bit_tick = 1'b0;
		rx_bit = 1'b0;
		repeat (12) @(negedge sys_clk);
		rst <= 1'b0;
		t_power();
		t_tx();
		t_rx();
		t_test();
		t_off();
		final_report();
	end
endmodule
`default_nettype wire
